// >>> src/sbrg_pkg.sv
// Shared constants and carrier types for the serial bit-rate generator.
// Assumes a single pclk domain and an APB master with 32-bit data.
package sbrg_pkg;

  // Register map, byte addresses on the APB bus.
  localparam logic [7:0] SBRG_OFF_RX_CTRL = 8'h00;
  localparam logic [7:0] SBRG_OFF_TX_CTRL = 8'h04;
  localparam logic [7:0] SBRG_OFF_DIVISOR = 8'h08;
  localparam logic [7:0] SBRG_OFF_TIMER = 8'h0c;
  localparam int SBRG_ADDR_W = 8;

  // Field positions in tx_status_control.
  localparam int SBRG_TX_SYNC_BIT = 4;
  localparam int SBRG_TX_GAP_BIT = 3;
  localparam int SBRG_TX_HS_BIT = 2;
  localparam int SBRG_TX_EMPTY_BIT = 1;

  // Field positions in rx_status_control.
  localparam int SBRG_RX_FRAME_BIT = 2;
  localparam int SBRG_RX_OVERRUN_BIT = 1;
  localparam int SBRG_RX_NINTH_BIT = 0;

  // Field positions in the timer readback word.
  localparam int SBRG_TMR_PRE_LSB = 8;

  // Reset values.
  localparam logic [7:0] SBRG_RST_DIVISOR = 8'h00;
  localparam logic [7:0] SBRG_RST_TX_CTRL = 8'h00;
  localparam logic [7:0] SBRG_RST_RX_CTRL = 8'h00;
  localparam logic SBRG_RST_TX_EMPTY = 1'b1;

  // Timer and prescaler sizes and rate multipliers.
  localparam int SBRG_DIV_W = 8;
  localparam int SBRG_PRE_W = 6;
  localparam logic [SBRG_PRE_W-1:0] SBRG_MULT_SLOW_M1 = 6'h3f;
  localparam logic [SBRG_PRE_W-1:0] SBRG_MULT_FAST_M1 = 6'h0f;
  localparam logic [SBRG_PRE_W-1:0] SBRG_MULT_SYNC_M1 = 6'h03;

  typedef struct packed {
    logic sync_mode;
    logic high_speed_select;
    logic [SBRG_DIV_W-1:0] baud_divisor;
  } sbrg_cfg_s;

  typedef struct packed {
    logic base_tick;
    logic bit_tick;
    logic [SBRG_PRE_W-1:0] prescale;
    logic [SBRG_DIV_W-1:0] count;
  } sbrg_tmr_s;

endpackage

// >>> src/sbrg_timer.sv
// Free-running bit-rate timer with its mode prescaler.
// Assumes the register block pulses restart for one cycle after a divisor write.
module sbrg_timer
  import sbrg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire sbrg_cfg_s cfg,
  input wire logic restart,
  output sbrg_tmr_s tmr
);

  ////////////////////////////////////////////////////////////////////////////

  // Last prescaler value of a bit period; sync mode never looks at high speed.
  function automatic logic [SBRG_PRE_W-1:0] mult_last(input sbrg_cfg_s c);
    if (c.sync_mode) begin
      mult_last = SBRG_MULT_SYNC_M1;
    end else if (c.high_speed_select) begin
      mult_last = SBRG_MULT_FAST_M1;
    end else begin
      mult_last = SBRG_MULT_SLOW_M1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  sbrg_tmr_s st_q;
  sbrg_tmr_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.base_tick = 1'b0;
    st_d.bit_tick = 1'b0;
    if (restart) begin
      st_d.count = '0;
      st_d.prescale = '0;
    end else if (st_q.count >= cfg.baud_divisor) begin
      // The compare is >= so a mode change can never strand the count.
      st_d.count = '0;
      st_d.base_tick = 1'b1;
      if (st_q.prescale >= mult_last(cfg)) begin
        st_d.prescale = '0;
        st_d.bit_tick = 1'b1;
      end else begin
        st_d.prescale = st_q.prescale + 1'b1;
      end
    end else begin
      st_d.count = st_q.count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tmr = st_q;

endmodule

// >>> src/sbrg_top.sv
// APB register block and top level of the serial bit-rate generator.
// Assumes transmitter and receiver status arrive from logic on pclk.
//
// Behaviour
// - One dedicated 8-bit timer times bits for asynchronous and synchronous modes.
// - The timer runs continuously with a period set by the baud divisor.
// - In asynchronous mode the high-speed select picks the period multiplier.
// - In synchronous mode the high-speed select is ignored.
// - Async, normal speed: bit rate is clock over 64 times divisor plus one.
// - Async, high speed: bit rate is clock over 16 times divisor plus one.
// - Synchronous: bit rate is clock over 4 times divisor plus one.
// - Writing the divisor clears the timer so the new rate starts at once.
// - Every reset clears the baud divisor to zero.
// - Sync select is bit 4, high-speed bit 2 of transmit control; both reset 0.
// - Unused bit 3 of transmit control always reads as zero.
//
// Implementation choices: the APB register port and the placing of the registers.
module sbrg_top
  import sbrg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SBRG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_shift_empty,
  input wire logic rx_framing_err,
  input wire logic rx_overrun_err,
  input wire logic rx_ninth_bit,
  output sbrg_cfg_s cfg,
  output logic [7:0] tx_ctrl_bits,
  output logic [7:0] rx_ctrl_bits,
  output logic base_tick,
  output logic bit_tick
);

  ////////////////////////////////////////////////////////////////////////////

  typedef enum logic [1:0] {
    SBRG_ST_IDLE = 2'b01,
    SBRG_ST_ACCESS = 2'b10
  } sbrg_apb_e;

  typedef struct packed {
    sbrg_apb_e phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] rx_ctrl;
    logic [7:0] tx_ctrl;
    logic [SBRG_DIV_W-1:0] divisor;
    logic restart;
    logic tx_empty;
    logic rx_frame;
    logic rx_overrun;
    logic rx_ninth;
  } sbrg_regs_s;

  sbrg_regs_s st_q;
  sbrg_regs_s st_d;
  sbrg_tmr_s tmr;

  ////////////////////////////////////////////////////////////////////////////

  // Address decode shared by the read and the write path.
  function automatic logic addr_mapped(input logic [SBRG_ADDR_W-1:0] a);
    unique case (a)
      SBRG_OFF_RX_CTRL: addr_mapped = 1'b1;
      SBRG_OFF_TX_CTRL: addr_mapped = 1'b1;
      SBRG_OFF_DIVISOR: addr_mapped = 1'b1;
      SBRG_OFF_TIMER: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // Transmit control as software sees it, with live status folded in.
  function automatic logic [7:0] tx_view(input sbrg_regs_s s);
    logic [7:0] v;
    v = s.tx_ctrl;
    v[SBRG_TX_GAP_BIT] = 1'b0;
    v[SBRG_TX_EMPTY_BIT] = s.tx_empty;
    tx_view = v;
  endfunction

  // Receive control with error and ninth-bit status folded in.
  function automatic logic [7:0] rx_view(input sbrg_regs_s s);
    logic [7:0] v;
    v = s.rx_ctrl;
    v[SBRG_RX_FRAME_BIT] = s.rx_frame;
    v[SBRG_RX_OVERRUN_BIT] = s.rx_overrun;
    v[SBRG_RX_NINTH_BIT] = s.rx_ninth;
    rx_view = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic setup_cyc;
  logic write_cyc;
  logic lane0;
  logic [7:0] wbyte;

  assign setup_cyc = psel && !penable;
  assign write_cyc = psel && penable && pwrite && st_q.pready && !st_q.pslverr;
  assign lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];

  always_comb begin
    st_d = st_q;
    st_d.restart = 1'b0;
    st_d.tx_empty = tx_shift_empty;
    st_d.rx_frame = rx_framing_err;
    st_d.rx_overrun = rx_overrun_err;
    st_d.rx_ninth = rx_ninth_bit;

    unique case (st_q.phase)
      SBRG_ST_IDLE: begin
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        if (setup_cyc) begin
          // The answer is prepared in setup so the access phase has no wait.
          st_d.phase = SBRG_ST_ACCESS;
          st_d.pready = 1'b1;
          st_d.pslverr = !addr_mapped(paddr);
          st_d.prdata = '0;
          if (!pwrite) begin
            unique case (paddr)
              SBRG_OFF_RX_CTRL: st_d.prdata[7:0] = rx_view(st_q);
              SBRG_OFF_TX_CTRL: st_d.prdata[7:0] = tx_view(st_q);
              SBRG_OFF_DIVISOR: st_d.prdata[SBRG_DIV_W-1:0] = st_q.divisor;
              SBRG_OFF_TIMER: begin
                st_d.prdata[SBRG_DIV_W-1:0] = tmr.count;
                st_d.prdata[SBRG_TMR_PRE_LSB +: SBRG_PRE_W] = tmr.prescale;
              end
              default: st_d.prdata = '0;
            endcase
          end
        end
      end
      SBRG_ST_ACCESS: begin
        // The access ends at this edge; drop ready so the next setup re-decodes.
        st_d.phase = SBRG_ST_IDLE;
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        if (write_cyc && lane0) begin
          unique case (paddr)
            SBRG_OFF_RX_CTRL: st_d.rx_ctrl = wbyte;
            SBRG_OFF_TX_CTRL: st_d.tx_ctrl = wbyte;
            SBRG_OFF_DIVISOR: begin
              st_d.divisor = wbyte;
              // Any write restarts, even the same value, as software expects.
              st_d.restart = 1'b1;
            end
            default: st_d.restart = 1'b0;
          endcase
        end
      end
      default: begin
        st_d.phase = SBRG_ST_IDLE;
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.phase <= SBRG_ST_IDLE;
      st_q.pready <= 1'b0;
      st_q.pslverr <= 1'b0;
      st_q.prdata <= '0;
      st_q.rx_ctrl <= SBRG_RST_RX_CTRL;
      st_q.tx_ctrl <= SBRG_RST_TX_CTRL;
      st_q.divisor <= SBRG_RST_DIVISOR;
      st_q.restart <= 1'b0;
      st_q.tx_empty <= SBRG_RST_TX_EMPTY;
      st_q.rx_frame <= 1'b0;
      st_q.rx_overrun <= 1'b0;
      st_q.rx_ninth <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  sbrg_cfg_s cfg_live;

  // Configuration seen by the timer comes straight from the stored registers.
  always_comb begin
    cfg_live.sync_mode = st_q.tx_ctrl[SBRG_TX_SYNC_BIT];
    cfg_live.high_speed_select = st_q.tx_ctrl[SBRG_TX_HS_BIT];
    cfg_live.baud_divisor = st_q.divisor;
  end

  sbrg_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg_live),
    .restart(st_q.restart),
    .tmr(tmr)
  );

  ////////////////////////////////////////////////////////////////////////////

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign cfg = cfg_live;
  assign tx_ctrl_bits = tx_view(st_q);
  assign rx_ctrl_bits = rx_view(st_q);
  assign base_tick = tmr.base_tick;
  assign bit_tick = tmr.bit_tick;

endmodule

// >>> testbench/sbrg_properties.sv
// Concurrent checks on the ports of the bit-rate generator top.
// Assumes it is bound to sbrg_top and sees only that module's ports.
module sbrg_props
  import sbrg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SBRG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sbrg_cfg_s cfg,
  input wire logic [7:0] tx_ctrl_bits,
  input wire logic base_tick,
  input wire logic bit_tick
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // Gap counters skip the cycles around a divisor write or mode change, where one period may be cut short.
  logic wr, skip, ok_q, ok2_q;
  logic [2:0] wr_q;
  logic [7:0] gap_q;
  logic rwait_q;
  logic [8:0] rcnt_q;
  logic [5:0] bcnt_q, m1;
  sbrg_cfg_s cfg_q;
  assign wr = psel && penable && pready && pwrite && paddr == SBRG_OFF_DIVISOR && pstrb[0];
  assign skip = wr || (|wr_q) || cfg != cfg_q;
  assign m1 = cfg.sync_mode ? 6'h03 : (cfg.high_speed_select ? 6'h0f : 6'h3f);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 3'h0;
      cfg_q <= '0;
      gap_q <= 8'h00;
      bcnt_q <= 6'h00;
      ok_q <= 1'b0;
      ok2_q <= 1'b0;
      rwait_q <= 1'b0;
      rcnt_q <= 9'h000;
    end else begin
      // Cycles from a divisor write to the first tick of the restarted timer.
      if (wr) begin
        rwait_q <= 1'b1;
        rcnt_q <= 9'h000;
      end else if (rwait_q) begin
        rcnt_q <= rcnt_q + 9'h001;
        rwait_q <= !(base_tick && rcnt_q != 9'h000);
      end
      wr_q <= {wr_q[1:0], wr};
      cfg_q <= cfg;
      gap_q <= base_tick ? 8'h00 : gap_q + 8'h01;
      bcnt_q <= bit_tick ? 6'h00 : bcnt_q + 6'(base_tick);
      ok_q <= skip ? 1'b0 : (base_tick ? 1'b1 : ok_q);
      ok2_q <= skip ? 1'b0 : (bit_tick ? 1'b1 : ok2_q);
    end
  end
  ////////////////////////////////////////////////////////////////
  property p_zero_wait; psel && !penable |=> pready; endproperty
  property p_ready_once; pready |=> !pready; endproperty
  property p_unmapped; psel && !penable && paddr > 8'h0c |=> pslverr && prdata == 32'h0; endproperty
  property p_gap_bit; tx_ctrl_bits[3] == 1'b0; endproperty
  property p_cfg_map; cfg.sync_mode == tx_ctrl_bits[4] && cfg.high_speed_select == tx_ctrl_bits[2]; endproperty
  property p_div_write; wr |=> cfg.baud_divisor == $past(pwdata[7:0]); endproperty
  property p_base_gap; base_tick && ok_q |-> gap_q == cfg.baud_divisor; endproperty
  property p_bit_in_base; bit_tick |-> base_tick; endproperty
  property p_bit_count; bit_tick && ok2_q |-> bcnt_q == m1; endproperty
  property p_restart; rwait_q && base_tick && rcnt_q != 9'h000 |-> rcnt_q == 9'(cfg.baud_divisor) + 9'h002; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("pready missing in access cycle");
  a_ready_once: assert property (p_ready_once) else $error("pready held too long");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_gap_bit: assert property (p_gap_bit) else $error("unused transmit bit not zero");
  a_cfg_map: assert property (p_cfg_map) else $error("mode bits misplaced");
  a_div_write: assert property (p_div_write) else $error("divisor not stored");
  a_base_gap: assert property (p_base_gap) else $error("base period wrong");
  a_bit_in_base: assert property (p_bit_in_base) else $error("bit tick off base tick");
  a_bit_count: assert property (p_bit_count) else $error("mode multiplier wrong");
  a_restart: assert property (p_restart) else $error("divisor write did not clear timer");
  c_sync: cover property (bit_tick && cfg.sync_mode);
  c_fast: cover property (bit_tick && ok2_q && cfg.high_speed_select && !cfg.sync_mode);
  c_err: cover property (pslverr);
  c_wr: cover property (wr);
endmodule
bind sbrg_top sbrg_props i_props (.*);

// >>> testbench/test_serial_baud_rate_generator.sv
// Self-checking bench for the serial bit-rate generator top.
// Assumes zero-wait APB answers and no other driver on the block's inputs.
module test_serial_baud_rate_generator;
  timeunit 1ns;
  timeprecision 1ps;
  import sbrg_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic tx_shift_empty = 1, rx_framing_err = 0, rx_overrun_err = 0, rx_ninth_bit = 0;
  logic [7:0] paddr = 8'h00, tx_ctrl_bits, rx_ctrl_bits;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, base_tick, bit_tick;
  sbrg_cfg_s cfg;
  int fail_count = 0, checks = 0, n, k;
  sbrg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_shift_empty(tx_shift_empty), .rx_framing_err(rx_framing_err), .rx_overrun_err(rx_overrun_err),
    .rx_ninth_bit(rx_ninth_bit), .cfg(cfg), .tx_ctrl_bits(tx_ctrl_bits), .rx_ctrl_bits(rx_ctrl_bits),
    .base_tick(base_tick), .bit_tick(bit_tick));
  initial begin
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Leaves read data and the error flag in rd and er.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int t;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 50) chk("pready", 1, 0);
  endtask
  // Cycles between two ticks of the chosen kind, starting from the next one seen.
  task automatic period(input logic sel);
    k = 0;
    // The tick launched at the write edge still belongs to the old rate, so it is skipped.
    repeat (2) @(negedge pclk);
    while ((sel ? bit_tick : base_tick) !== 1'b1 && k < 600) begin
      @(negedge pclk);
      k++;
    end
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((sel ? bit_tick : base_tick) !== 1'b1 && n < 600);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(0, SBRG_OFF_TX_CTRL, 0, 4'hf); chk("tx reset", 32'h02, rd);
    apb(0, SBRG_OFF_DIVISOR, 0, 4'hf); chk("div reset", 32'h00, rd);
    tx_shift_empty <= 0;
    {rx_framing_err, rx_ninth_bit} <= 2'b11;
    apb(1, SBRG_OFF_TX_CTRL, 32'hff, 4'hf);
    apb(0, SBRG_OFF_TX_CTRL, 0, 4'hf); chk("tx bits", 32'hf5, rd);
    apb(0, SBRG_OFF_RX_CTRL, 0, 4'hf); chk("rx bits", 32'h05, rd);
    chk("rx view", 32'h05, {24'h0, rx_ctrl_bits});
    apb(1, SBRG_OFF_DIVISOR, 32'h55, 4'h0);
    apb(0, SBRG_OFF_DIVISOR, 0, 4'hf); chk("strobe off", 32'h00, rd);
    apb(0, 8'h10, 0, 4'hf); chk("unmapped err", 1, er);
    $display("register test done");
  endtask
  task automatic t_modes;
    logic [7:0] md [4] = '{8'h00, 8'h04, 8'h10, 8'h14};
    int ml [4] = '{64, 16, 4, 4};
    for (int i = 0; i < 4; i++) begin
      apb(1, SBRG_OFF_TX_CTRL, {24'h0, md[i]}, 4'hf);
      apb(1, SBRG_OFF_DIVISOR, 32'h02, 4'hf);
      period(1); chk("bit period", ml[i] * 3, n);
      period(0); chk("base period", 3, n);
    end
    $display("mode test done");
  endtask
  task automatic t_restart;
    apb(1, SBRG_OFF_DIVISOR, 32'hc8, 4'hf);
    repeat (100) @(posedge pclk);
    // The same value again: only a restart can push the next tick a full period out.
    apb(1, SBRG_OFF_DIVISOR, 32'hc8, 4'hf);
    period(0);
    chk("restart wait", 32'hc9, k);
    chk("long period", 32'hc9, n);
    apb(1, SBRG_OFF_DIVISOR, 32'h03, 4'hf);
    apb(0, SBRG_OFF_TIMER, 0, 4'hf);
    chk("timer cleared", 32'h0, rd);
    period(0);
    chk("new period", 32'h04, n);
    $display("restart test done");
  endtask
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_modes();
    t_restart();
    end_sim();
  end
endmodule
